//--- include/gyro_cfg_pkg.sv
// Shared constants and types for the rate filter configuration block.
package gyro_cfg_pkg;

  localparam logic [7:0] ADDR_RATE_DIVIDER = 8'h19;
  localparam logic [7:0] ADDR_FILTER_SYNC = 8'h1A;
  localparam logic [7:0] ADDR_RATE_RANGE = 8'h1B;

  localparam logic [7:0] RESET_RATE_DIVIDER = 8'h00;
  localparam logic [7:0] RESET_FILTER_SYNC = 8'h00;
  localparam logic [7:0] RESET_RATE_RANGE = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Bit 7 of the filter register and bit 2 of the range register read as zero.
  localparam logic [7:0] FILTER_SYNC_MASK = 8'h7F;
  localparam logic [7:0] RATE_RANGE_MASK = 8'hFB;

  localparam int POLICY_BIT = 6;
  localparam int SYNC_LSB = 3;
  localparam int LOWPASS_LSB = 0;
  localparam int SELFTEST_LSB = 5;
  localparam int RANGE_LSB = 3;
  localparam int BYPASS_LSB = 0;

  localparam logic [2:0] SYNC_OFF = 3'h0;
  localparam logic [2:0] SYNC_TEMP = 3'h1;
  localparam logic [2:0] SYNC_X = 3'h2;
  localparam logic [2:0] SYNC_Y = 3'h3;
  localparam logic [2:0] SYNC_Z = 3'h4;

  localparam logic [1:0] BYPASS_NONE = 2'h0;
  localparam logic [1:0] BYPASS_NARROW = 2'h2;
  localparam logic [2:0] LOWPASS_WIDE = 3'h0;
  localparam logic [2:0] LOWPASS_FAST = 3'h7;

  localparam logic [11:0] BASE_SCALE_DPS = 12'h0FA;

  localparam int CLK_PERIOD_NS = 10;
  localparam int PERIOD_1K_NS = 1000000;
  localparam int PERIOD_8K_NS = 125000;
  localparam int PERIOD_32K_NS = 31250;
  localparam int CYCLES_1K = PERIOD_1K_NS / CLK_PERIOD_NS;
  localparam int CYCLES_8K = PERIOD_8K_NS / CLK_PERIOD_NS;
  localparam int CYCLES_32K = PERIOD_32K_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {RATE_32K, RATE_8K, RATE_1K} rate_class_t;

  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } sample_t;

  typedef struct packed {
    logic [13:0] rate_bw_hz;
    logic [12:0] temp_bw_hz;
    logic [5:0] rate_khz;
    logic [11:0] full_scale_dps;
  } filter_status_t;

endpackage

//--- design/queue_writer.sv
// Byte sequencer that pushes one output sample into the external sample queue.
`timescale 1ns/100ps
`default_nettype none

module queue_writer (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Sample hand-off
  input wire logic start_in,
  input wire gyro_cfg_pkg::sample_t sample_in,
  input wire logic [3:0] enable_in,
  input wire logic discard_when_full_in,
  // Queue write side
  input wire logic queue_full_in,
  output logic queue_write_out,
  output logic [7:0] queue_data_out,
  output logic queue_overwrite_out
);
  import gyro_cfg_pkg::*;

  typedef enum logic [1:0] {WRITER_IDLE, WRITER_HIGH, WRITER_LOW} writer_state_t;

  writer_state_t state;
  logic [1:0] chan;
  sample_t held;
  logic [3:0][15:0] words;
  logic chan_on;
  logic blocked;

  // Index 3 is temperature, then x, y, z down to index 0.
  assign words = held;
  assign chan_on = enable_in[chan];
  assign blocked = queue_full_in && discard_when_full_in;

  // A new sample restarts the walk; at the fastest setting there are thousands of idle cycles.
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state <= WRITER_IDLE;
      chan <= 2'h3;
      held <= '0;
    end else if (start_in) begin
      state <= WRITER_HIGH;
      chan <= 2'h3;
      held <= sample_in;
    end else begin
      case (state)
        WRITER_HIGH: begin
          state <= WRITER_LOW;
        end
        WRITER_LOW: begin
          if (chan == 2'h0) begin
            state <= WRITER_IDLE;
          end else begin
            state <= WRITER_HIGH;
          end
          chan <= chan - 2'h1;
        end
        default: begin
          state <= WRITER_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      queue_write_out <= 1'b0;
      queue_data_out <= 8'h00;
      queue_overwrite_out <= 1'b0;
    end else begin
      queue_write_out <= 1'b0;
      queue_overwrite_out <= 1'b0;
      if (!start_in && state != WRITER_IDLE && chan_on) begin // [RL11]
        queue_write_out <= !blocked; // [RL4]
        queue_overwrite_out <= queue_full_in && !discard_when_full_in; // [RL4]
        queue_data_out <= (state == WRITER_HIGH) ? words[chan][15:8] : words[chan][7:0]; // [RL11]
      end
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  a_discard_when_full: assert property ( // [RL4]
    queue_full_in && discard_when_full_in |=> !queue_write_out)
    else $error("queue written while full under discard policy");

  a_overwrite_when_full: assert property ( // [RL4]
    queue_full_in && !discard_when_full_in && state != WRITER_IDLE && chan_on && !start_in
    |=> queue_write_out && queue_overwrite_out)
    else $error("full queue not overwritten under replace policy");

  a_all_bytes_written: assert property ( // [RL11]
    start_in && enable_in == 4'hF && !queue_full_in ##1 (!start_in && !queue_full_in && enable_in == 4'hF) [*8]
    |=> queue_write_out)
    else $error("last byte of a full sample missing");

  c_full_sample: cover property (start_in && enable_in == 4'hF ##9 queue_write_out);
endmodule

`default_nettype wire

//--- design/gyro_rate_filter_config.sv
// Sample timing, filter selection, range and frame-sync insertion for a rate sensor.
//
// Overview of operation
// [RL1] Output rate is internal rate over divider plus one.
// [RL2] Divider only acts with bypass 00, selection 1..6.
// [RL3] Divided rate updates outputs and feeds queue.
// [RL4] Full queue: policy one discards, zero overwrites oldest.
// [RL5] Sync placement picks temperature, x, y, z bit.
// [RL6] Frame-sync toggles latched, captured on sample strobe.
// [RL7] Rate and temperature filtered per selection and bypass.
// [RL8] Bypass codes run at 32 kHz, wide bandwidth.
// [RL9] Bypass 00 selections give table bandwidths and rates.
// [RL10] Range field picks 250 to 2000 dps.
// [RL11] Enabled channel bytes queued once per sample.
// [RL12] Ineffective divider leaves internal rate unchanged.
// [RL13] Host writes zero to reserved and top bits.
`timescale 1ns/100ps
`default_nettype none

module gyro_rate_filter_config #(
  parameter int PERIOD_1K_CYCLES = gyro_cfg_pkg::CYCLES_1K,
  parameter int PERIOD_8K_CYCLES = gyro_cfg_pkg::CYCLES_8K
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_write_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_read_in,
  output logic [7:0] reg_rdata_out,
  // Sensor data and frame sync
  input wire gyro_cfg_pkg::sample_t raw_sample_in,
  input wire logic frame_sync_in,
  // Sample queue
  input wire logic [3:0] queue_enable_in,
  input wire logic queue_full_in,
  output logic queue_write_out,
  output logic [7:0] queue_data_out,
  output logic queue_overwrite_out,
  // Sample outputs and status
  output logic sample_strobe_out,
  output gyro_cfg_pkg::sample_t sample_out,
  output gyro_cfg_pkg::filter_status_t filter_status_out,
  output logic [2:0] selftest_out
);
  import gyro_cfg_pkg::*;

  logic [7:0] rate_divider;
  logic [7:0] filter_sync_config;
  logic [7:0] rate_range_config;

  logic discard_when_full;
  logic [2:0] sync_placement;
  logic [2:0] lowpass_select;
  logic [1:0] range_select;
  logic [1:0] filter_bypass_code;
  rate_class_t rate_class;
  logic divider_effective;

  logic [16:0] tick_cnt;
  logic [16:0] period_last;
  logic tick;
  logic [7:0] div_cnt;
  logic next_strobe;

  logic sync_meta;
  logic sync_level;
  logic sync_prev;
  logic sync_edge;
  logic frame_sync_seen;
  logic sync_bit;
  sample_t next_sample;
  filter_status_t next_status;

  assign discard_when_full = filter_sync_config[POLICY_BIT];
  assign sync_placement = filter_sync_config[SYNC_LSB +: 3];
  assign lowpass_select = filter_sync_config[LOWPASS_LSB +: 3];
  assign range_select = rate_range_config[RANGE_LSB +: 2];
  assign filter_bypass_code = rate_range_config[BYPASS_LSB +: 2];

  // Registers; reserved bits are dropped on write so they always read zero.
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rate_divider <= RESET_RATE_DIVIDER;
      filter_sync_config <= RESET_FILTER_SYNC;
      rate_range_config <= RESET_RATE_RANGE;
    end else if (reg_write_in) begin
      if (reg_addr_in == ADDR_RATE_DIVIDER) begin
        rate_divider <= reg_wdata_in;
      end else if (reg_addr_in == ADDR_FILTER_SYNC) begin
        filter_sync_config <= reg_wdata_in & FILTER_SYNC_MASK; // [RL13]
      end else if (reg_addr_in == ADDR_RATE_RANGE) begin
        rate_range_config <= reg_wdata_in & RATE_RANGE_MASK; // [RL13]
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      reg_rdata_out <= READ_UNMAPPED;
    end else if (reg_read_in) begin
      if (reg_addr_in == ADDR_RATE_DIVIDER) begin
        reg_rdata_out <= rate_divider;
      end else if (reg_addr_in == ADDR_FILTER_SYNC) begin
        reg_rdata_out <= filter_sync_config;
      end else if (reg_addr_in == ADDR_RATE_RANGE) begin
        reg_rdata_out <= rate_range_config;
      end else begin
        reg_rdata_out <= READ_UNMAPPED;
      end
    end
  end

  // Internal rate class follows bypass first, then the low-pass selection.
  always_comb begin
    if (filter_bypass_code != BYPASS_NONE) begin
      rate_class = RATE_32K; // [RL8]
    end else if (lowpass_select == LOWPASS_WIDE || lowpass_select == LOWPASS_FAST) begin
      rate_class = RATE_8K; // [RL9]
    end else begin
      rate_class = RATE_1K; // [RL9]
    end
  end

  assign divider_effective = (rate_class == RATE_1K); // [RL2]

  always_comb begin
    case (rate_class)
      RATE_32K: period_last = 17'(CYCLES_32K - 1);
      RATE_8K: period_last = 17'(PERIOD_8K_CYCLES - 1);
      default: period_last = 17'(PERIOD_1K_CYCLES - 1);
    endcase
  end

  // The count restarts at once if a mode change moves the period end to or below the count.
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tick_cnt <= 17'h00000;
      tick <= 1'b0;
    end else if (tick_cnt >= period_last) begin
      tick_cnt <= 17'h00000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 17'h00001;
      tick <= 1'b0;
    end
  end

  assign next_strobe = tick && (!divider_effective || div_cnt >= rate_divider); // [RL1] [RL12]

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      div_cnt <= 8'h00;
    end else if (tick) begin
      if (next_strobe) begin
        div_cnt <= 8'h00; // [RL1]
      end else begin
        div_cnt <= div_cnt + 8'h01; // [RL1]
      end
    end
  end

  // Frame sync is a pin: two flops first, edges are taken only after the second.
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sync_meta <= 1'b0;
      sync_level <= 1'b0;
      sync_prev <= 1'b0;
    end else begin
      sync_meta <= frame_sync_in;
      sync_level <= sync_meta;
      sync_prev <= sync_level;
    end
  end

  assign sync_edge = sync_level ^ sync_prev;
  assign sync_bit = frame_sync_seen | sync_edge; // [RL6]

  // A toggle in the strobe cycle is kept for the following sample, so set wins.
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      frame_sync_seen <= 1'b0;
    end else if (sync_edge) begin
      frame_sync_seen <= 1'b1; // [RL6]
    end else if (next_strobe) begin
      frame_sync_seen <= 1'b0; // [RL6]
    end
  end

  always_comb begin
    next_sample = raw_sample_in;
    case (sync_placement)
      SYNC_TEMP: next_sample.temp[0] = sync_bit; // [RL5]
      SYNC_X: next_sample.x[0] = sync_bit; // [RL5]
      SYNC_Y: next_sample.y[0] = sync_bit; // [RL5]
      SYNC_Z: next_sample.z[0] = sync_bit; // [RL5]
      default: next_sample = raw_sample_in;
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sample_strobe_out <= 1'b0;
      sample_out <= '0;
    end else begin
      sample_strobe_out <= next_strobe; // [RL3]
      if (next_strobe) begin
        sample_out <= next_sample; // [RL3]
      end
    end
  end

  // Filter bandwidths for the rate and temperature paths.
  always_comb begin
    next_status.full_scale_dps = BASE_SCALE_DPS << range_select; // [RL10]
    next_status.rate_khz = 6'h01;
    if (filter_bypass_code[0]) begin
      next_status.rate_bw_hz = 14'h1FED; // [RL8]
      next_status.temp_bw_hz = 13'h0FA0; // [RL7]
      next_status.rate_khz = 6'h20;
    end else if (filter_bypass_code == BYPASS_NARROW) begin
      next_status.rate_bw_hz = 14'h0CD1; // [RL8]
      next_status.temp_bw_hz = 13'h0FA0; // [RL7]
      next_status.rate_khz = 6'h20;
    end else begin
      case (lowpass_select) // [RL9] [RL7]
        3'h0: begin
          next_status.rate_bw_hz = 14'h00FA;
          next_status.temp_bw_hz = 13'h0FA0;
          next_status.rate_khz = 6'h08;
        end
        3'h1: begin
          next_status.rate_bw_hz = 14'h00B0;
          next_status.temp_bw_hz = 13'h00BC;
        end
        3'h2: begin
          next_status.rate_bw_hz = 14'h005C;
          next_status.temp_bw_hz = 13'h0062;
        end
        3'h3: begin
          next_status.rate_bw_hz = 14'h0029;
          next_status.temp_bw_hz = 13'h002A;
        end
        3'h4: begin
          next_status.rate_bw_hz = 14'h0014;
          next_status.temp_bw_hz = 13'h0014;
        end
        3'h5: begin
          next_status.rate_bw_hz = 14'h000A;
          next_status.temp_bw_hz = 13'h000A;
        end
        3'h6: begin
          next_status.rate_bw_hz = 14'h0005;
          next_status.temp_bw_hz = 13'h0005;
        end
        default: begin
          next_status.rate_bw_hz = 14'h0CD1;
          next_status.temp_bw_hz = 13'h0FA0;
          next_status.rate_khz = 6'h08;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      filter_status_out <= '0;
      selftest_out <= 3'h0;
    end else begin
      filter_status_out <= next_status; // [RL7] [RL10]
      selftest_out <= rate_range_config[SELFTEST_LSB +: 3];
    end
  end

  queue_writer i_queue_writer (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .start_in(next_strobe), // [RL3]
    .sample_in(next_sample),
    .enable_in(queue_enable_in),
    .discard_when_full_in(discard_when_full), // [RL4]
    .queue_full_in(queue_full_in),
    .queue_write_out(queue_write_out),
    .queue_data_out(queue_data_out),
    .queue_overwrite_out(queue_overwrite_out)
  );

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  a_divider_fires: assert property ( // [RL1]
    tick && divider_effective && div_cnt >= rate_divider |=> sample_strobe_out)
    else $error("divider did not fire at its count");
  a_divider_holds: assert property ( // [RL1]
    tick && divider_effective && div_cnt < rate_divider |=> !sample_strobe_out)
    else $error("divider fired early");
  a_divider_bypassed: assert property ( // [RL2]
    tick && !divider_effective |=> sample_strobe_out)
    else $error("divider acted while ineffective");
  a_tick_spacing: assert property ( // [RL12]
    tick |=> (!tick) [*8])
    else $error("internal ticks too close");
  a_output_hold: assert property ( // [RL3]
    !next_strobe |=> $stable(sample_out))
    else $error("sample output changed without strobe");
  a_sync_in_x: assert property ( // [RL5]
    next_strobe && sync_placement == SYNC_X |=> sample_out.x[0] == $past(sync_bit))
    else $error("frame sync bit missing from x word");
  a_sync_off: assert property ( // [RL5]
    next_strobe && sync_placement == SYNC_OFF |=> sample_out == $past(raw_sample_in))
    else $error("sample altered with sync disabled");
  a_sync_latch: assert property ( // [RL6]
    sync_edge |=> frame_sync_seen)
    else $error("frame sync toggle lost");
  a_range_scale: assert property ( // [RL10]
    range_select == 2'h2 |=> filter_status_out.full_scale_dps == 12'h3E8)
    else $error("full scale wrong for range two");
  a_bypass_wide: assert property ( // [RL8]
    filter_bypass_code[0] |=> filter_status_out.rate_bw_hz == 14'h1FED && filter_status_out.rate_khz == 6'h20)
    else $error("bypass bandwidth wrong");
  a_lowpass_six: assert property ( // [RL9]
    filter_bypass_code == BYPASS_NONE && lowpass_select == 3'h6
    |=> filter_status_out.rate_bw_hz == 14'h0005 && filter_status_out.temp_bw_hz == 13'h0005)
    else $error("narrowest low-pass setting wrong");

  c_divided_strobe: cover property (divider_effective && rate_divider == 8'h02 && next_strobe);
  c_sync_captured: cover property (sync_edge ##[1:20] next_strobe && sync_placement == SYNC_Z);
  c_bypass_strobe: cover property (filter_bypass_code == BYPASS_NARROW && next_strobe);
endmodule

`default_nettype wire

//--- sim/queue_sink_model.sv
// Behavioural sample queue that sits on the write side of the block's queue port.
`timescale 1ns/100ps
`default_nettype none

module queue_sink_model #(
  parameter int CAP = 8
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Bench control
  input wire logic flush_in,
  // Queue write side
  input wire logic write_in,
  input wire logic [7:0] data_in,
  input wire logic overwrite_in,
  output logic full_out
);
  logic [7:0] mem [0:CAP-1];
  int count;

  assign full_out = (count == CAP);

  // A plain write that lands while full is lost, just as a real queue would lose it.
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      count <= 0;
    end else if (flush_in) begin
      count <= 0;
    end else if (overwrite_in && count == CAP) begin
      for (int i = 0; i < CAP - 1; i++) begin
        mem[i] <= mem[i + 1];
      end
      mem[CAP - 1] <= data_in;
    end else if (write_in && count < CAP) begin
      mem[count] <= data_in;
      count <= count + 1;
    end
  end
endmodule
`default_nettype wire

//--- sim/gyro_rate_filter_config_tb.sv
// Self-checking bench for the rate filter configuration block.
`timescale 1ns/100ps
`default_nettype none

module gyro_rate_filter_config_tb;
  import gyro_cfg_pkg::*;
  // Short periods keep the run small; the 32 kHz period stays at its real length.
  localparam int P1K = 40;
  localparam int P8K = 20;
  localparam logic [63:0] S1 = 64'h1235_4567_89AB_CDEF;
  localparam logic [63:0] S2 = 64'hFEDB_A987_6543_2101;
  localparam logic [63:0] S3 = 64'h0F0F_F0F1_3C3D_C3C3;
  localparam int BW[10] = '{250, 176, 92, 41, 20, 10, 5, 3281, 8173, 3281};
  localparam int TBW[10] = '{4000, 188, 98, 42, 20, 10, 5, 4000, 4000, 4000};
  localparam int KHZ[10] = '{8, 1, 1, 1, 1, 1, 1, 8, 32, 32};
  localparam logic [7:0] PD[6] = '{8'h00, 8'h05, 8'h02, 8'hFF, 8'h05, 8'h02};
  localparam logic [7:0] PF[6] = '{8'h00, 8'h07, 8'h03, 8'h06, 8'h03, 8'h03};
  localparam logic [7:0] PB[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02};
  localparam int PEXP[6] = '{P8K, P8K, 3 * P1K, 256 * P1K, CYCLES_32K, CYCLES_32K};

  logic ref_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic reg_write_in = 1'b0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_read_in = 1'b0;
  logic [7:0] reg_rdata_out;
  sample_t raw_sample_in = S1;
  logic frame_sync_in = 1'b0;
  logic [3:0] queue_enable_in = 4'h0;
  logic queue_full_in;
  logic queue_write_out;
  logic [7:0] queue_data_out;
  logic queue_overwrite_out;
  logic sample_strobe_out;
  sample_t sample_out;
  filter_status_t filter_status_out;
  logic [2:0] selftest_out;
  logic flush = 1'b0;
  int error_cnt = 0;
  int cmp_count = 0;

  always #(CLK_PERIOD_NS / 2) ref_clk_in = ~ref_clk_in;

  gyro_rate_filter_config #(.PERIOD_1K_CYCLES(P1K), .PERIOD_8K_CYCLES(P8K)) i_gyro_rate_filter_config (
    .ref_clk_in, .reset_in, .reg_addr_in, .reg_write_in, .reg_wdata_in, .reg_read_in, .reg_rdata_out,
    .raw_sample_in, .frame_sync_in, .queue_enable_in, .queue_full_in, .queue_write_out, .queue_data_out,
    .queue_overwrite_out, .sample_strobe_out, .sample_out, .filter_status_out, .selftest_out
  );

  queue_sink_model #(.CAP(8)) i_queue_sink_model (
    .ref_clk_in, .reset_in, .flush_in(flush), .write_in(queue_write_out), .data_in(queue_data_out),
    .overwrite_in(queue_overwrite_out), .full_out(queue_full_in)
  );

  task automatic complete_run;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Every bus task starts and ends just after a falling edge.
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_write_in = 1'b1;
    @(negedge ref_clk_in);
    reg_write_in = 1'b0;
    @(negedge ref_clk_in);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr_in = a;
    reg_read_in = 1'b1;
    @(negedge ref_clk_in);
    reg_read_in = 1'b0;
    chk(reg_rdata_out, exp);
    @(negedge ref_clk_in);
  endtask

  task automatic cfg(input logic [7:0] d, input logic [7:0] f, input logic [7:0] r);
    reg_write(ADDR_RATE_DIVIDER, d);
    reg_write(ADDR_FILTER_SYNC, f);
    reg_write(ADDR_RATE_RANGE, r);
  endtask

  // Returns in the strobe cycle with the number of cycles waited.
  task automatic wait_strobe(output int n);
    n = 0;
    do begin
      @(negedge ref_clk_in);
      n++;
    end while (sample_strobe_out !== 1'b1 && n < 12000);
    if (n >= 12000) begin
      error_cnt++;
      complete_run();
    end
  endtask

  task automatic t_regs;
    rd(ADDR_RATE_DIVIDER, RESET_RATE_DIVIDER);
    rd(ADDR_FILTER_SYNC, RESET_FILTER_SYNC);
    rd(ADDR_RATE_RANGE, RESET_RATE_RANGE);
    reg_write(8'h1C, 8'h5A);
    rd(8'h1C, READ_UNMAPPED);
    reg_write(ADDR_FILTER_SYNC, 8'h67);
    rd(ADDR_FILTER_SYNC, 8'h67);
    reg_write(ADDR_RATE_RANGE, 8'hFB);
    rd(ADDR_RATE_RANGE, 8'hFB);
    chk(selftest_out, 3'h7);
    cfg(8'hFF, 8'h00, 8'h00);
    rd(ADDR_RATE_DIVIDER, 8'hFF);
  endtask

  task automatic t_status;
    logic [1:0] b;
    for (int i = 0; i < 10; i++) begin
      b = (i == 8) ? 2'h3 : (i == 9) ? 2'h2 : 2'h0;
      cfg(8'h00, {5'h00, i[2:0]}, {3'h0, i[1:0], 1'b0, b});
      @(negedge ref_clk_in);
      chk(filter_status_out, {BW[i][13:0], TBW[i][12:0], KHZ[i][5:0], 12'(250 << i[1:0])});
    end
  endtask

  task automatic t_rate;
    int n;
    for (int i = 0; i < 6; i++) begin
      cfg(PD[i], PF[i], PB[i]);
      wait_strobe(n);
      wait_strobe(n);
      raw_sample_in = S2 ^ 64'(i);
      wait_strobe(n);
      chk(n, PEXP[i]);
      chk(sample_out, S2 ^ 64'(i));
    end
  endtask

  task automatic t_sync;
    int n;
    logic [63:0] e;
    raw_sample_in = S1;
    for (int p = 0; p < 5; p++) begin
      cfg(8'h00, {2'h0, p[2:0], 3'h0}, 8'h00);
      wait_strobe(n);
      frame_sync_in = 1'b1;
      @(negedge ref_clk_in);
      frame_sync_in = 1'b0;
      for (int f = 1; f >= 0; f--) begin
        // Raw low bits sit opposite to the expected sync bit, so a missing insertion shows.
        raw_sample_in = f[0] ? (S1 & 64'hFFFE_FFFE_FFFE_FFFE) : S1;
        wait_strobe(n);
        e = raw_sample_in;
        if (p >= 1 && p <= 4) begin
          e[64 - 16 * p] = f[0];
        end
        chk(sample_out, e);
      end
    end
  endtask

  task automatic t_bytes(input logic [63:0] s, input logic [3:0] en, input logic wr, input logic ov);
    for (int k = 0; k < 8; k++) begin
      @(negedge ref_clk_in);
      flush = 1'b0;
      chk(queue_write_out, en[3 - k / 2] & wr);
      chk(queue_overwrite_out, en[3 - k / 2] & ov);
      if (en[3 - k / 2] & wr) begin
        chk(queue_data_out, s[63 - 8 * k -: 8]);
      end
    end
  endtask

  task automatic t_mem(input logic [63:0] s);
    // The last byte lands in the queue one edge after its pulse is seen.
    @(negedge ref_clk_in);
    for (int k = 0; k < 8; k++) begin
      chk(i_queue_sink_model.mem[k], s[63 - 8 * k -: 8]);
    end
  endtask

  task automatic t_queue;
    int n;
    cfg(8'h00, 8'h00, 8'h00);
    raw_sample_in = S1;
    queue_enable_in = 4'hF;
    wait_strobe(n);
    // The queue is held empty before the strobe, so the first byte sees no full queue.
    flush = 1'b1;
    wait_strobe(n);
    t_bytes(S1, 4'hF, 1'b1, 1'b0);
    t_mem(S1);
    reg_write(ADDR_FILTER_SYNC, 8'h40);
    raw_sample_in = S2;
    wait_strobe(n);
    t_bytes(S2, 4'hF, 1'b0, 1'b0);
    t_mem(S1);
    reg_write(ADDR_FILTER_SYNC, 8'h00);
    raw_sample_in = S3;
    wait_strobe(n);
    t_bytes(S3, 4'hF, 1'b1, 1'b1);
    t_mem(S3);
    queue_enable_in = 4'h5;
    wait_strobe(n);
    wait_strobe(n);
    t_bytes(S3, 4'h5, 1'b1, 1'b1);
  endtask

  initial begin
    repeat (12) @(negedge ref_clk_in);
    reset_in = 1'b0;
    @(negedge ref_clk_in);
    t_regs();
    t_status();
    t_rate();
    t_sync();
    t_queue();
    complete_run();
  end
endmodule
`default_nettype wire
